// *** common/dcf_pkg.sv ***
//////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants and types for the FIFO flag and threshold block.
// Assumes: One clock for the write side and the read side.
// Notes:   The widths, depths, threshold reset values and fall-through extra word used by the design are named here.
//////////////////////////////////////////////////////////////////////////////
package dcf_pkg;

    // Data path, threshold and count widths.
    localparam int unsigned DATA_W    = 18;
    localparam int unsigned OFS_W     = 12;
    localparam int unsigned CNT_W     = 14;

    // Default depth, and the depth steps that pick the threshold defaults.
    localparam int unsigned DEPTH_DEF = 256;
    localparam int unsigned DEPTH_S   = 256;
    localparam int unsigned DEPTH_M   = 512;

    // Threshold reset values per depth step.
    localparam logic [OFS_W-1:0] AE_DEF_S   = 12'h01f;
    localparam logic [OFS_W-1:0] AE_DEF_M   = 12'h03f;
    localparam logic [OFS_W-1:0] AE_DEF_L   = 12'h07f;

    // Extra word held by the output register in fall-through mode.
    localparam logic [CNT_W-1:0] FT_EXTRA   = 14'h0001;

    // Read-clock edges from a write into an empty FIFO to the word on the outputs.
    localparam int unsigned FT_LAT_EDGES    = 3;

    // Clock period in nanoseconds.
    localparam int unsigned CLK_PERIOD_NS   = 20;

    // Mode strap positions as sampled during reset.
    typedef struct packed {
        logic fall_through_mode;
        logic psync;
    } dcf_cfg_t;

    // Threshold register selected by the load sequence.
    typedef enum logic [0:0] {
        SEL_AE = 1'b0,
        SEL_AF = 1'b1
    } dcf_sel_t;

endpackage

// *** hw/dcf_buf2.sv ***
//////////////////////////////////////////////////////////////////////////////
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Single clock, synchronous active-low reset.
// Notes:   Input ready is high whenever fewer than two words are held.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module dcf_buf2 #(
    parameter int unsigned W = dcf_pkg::DATA_W
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         nrst_i,
    // Filling side
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    // Draining side
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);

    logic [W-1:0] head_r;
    logic [W-1:0] tail_r;
    logic [1:0]   cnt_r;
    logic         push;
    logic         pop;

    assign in_ready_o  = (cnt_r != 2'h2);
    assign out_valid_o = (cnt_r != 2'h0);
    assign out_data_o  = head_r;
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            cnt_r <= 2'h0;
        end else begin
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end

    // A word that arrives while the head leaves slides straight into place.
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            head_r <= '0;
            tail_r <= '0;
        end else begin
            if (pop) begin
                head_r <= (cnt_r == 2'h2) ? tail_r : in_data_i;
                if (push && cnt_r == 2'h2) begin
                    tail_r <= in_data_i;
                end
            end else if (push) begin
                if (cnt_r == 2'h0) begin
                    head_r <= in_data_i;
                end else begin
                    tail_r <= in_data_i;
                end
            end
        end
    end

endmodule

// *** hw/dcf_flags_top.sv ***
//////////////////////////////////////////////////////////////////////////////
// Purpose: FIFO with status flags, threshold registers and output enable.
// Assumes: Write and read sides share clk_i; nrst_i is synchronous.
// Notes:   Flags are active low at the pins, as on the device they model.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module dcf_flags_top #(
    parameter int unsigned DEPTH = dcf_pkg::DEPTH_DEF,
    parameter int unsigned DW    = dcf_pkg::DATA_W
) (
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          nrst_i,
    // Write port
    input  wire logic [DW-1:0] write_data_i,
    input  wire logic          write_en_n_i,
    input  wire logic          threshold_load_n_i,
    // Read port
    input  wire logic          read_en_n_i,
    input  wire logic          output_enable_n_i,
    output logic [DW-1:0]      read_data_bus_o,
    output logic               read_data_bus_oe_o,
    // Mode straps
    input  wire logic          first_load_n_i,
    input  wire logic          write_expansion_in_n_i,
    input  wire logic          read_expansion_in_n_i,
    // Flags
    output logic               full_flag_n_o,
    output logic               empty_flag_n_o,
    output logic               almost_full_flag_n_o,
    output logic               almost_empty_flag_n_o
);

    localparam int unsigned          AW     = $clog2(DEPTH);
    localparam int unsigned          CW     = dcf_pkg::CNT_W;
    localparam logic [CW-1:0]        CAP_SD = CW'(DEPTH);
    localparam logic [AW-1:0]        PTR_MX = AW'(DEPTH - 1);
    localparam logic [dcf_pkg::OFS_W-1:0] AE_DEF =
        (DEPTH <= dcf_pkg::DEPTH_S) ? dcf_pkg::AE_DEF_S :
        (DEPTH <= dcf_pkg::DEPTH_M) ? dcf_pkg::AE_DEF_M : dcf_pkg::AE_DEF_L;
    localparam logic [dcf_pkg::OFS_W-1:0] AF_DEF = AE_DEF;

    ////////////////////////////////////////////////////////////////////////////
    // Mode straps.

    dcf_pkg::dcf_cfg_t cfg_r;
    logic [CW-1:0]     cap;

    // Straps are caught by the clock while reset is held, never asynchronously.
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            cfg_r.fall_through_mode  <= !read_expansion_in_n_i && write_expansion_in_n_i;
            cfg_r.psync <= first_load_n_i;
        end
    end

    assign cap = cfg_r.fall_through_mode ? (CAP_SD + dcf_pkg::FT_EXTRA) : CAP_SD;

    ////////////////////////////////////////////////////////////////////////////
    // Request decode.

    logic          wr_req;
    logic          ofs_wr;
    logic          ofs_rd_req;
    logic          ofs_rd;
    logic          full_int;
    logic          b_in_ready;
    logic          b_out_valid;
    logic          b_out_ready;
    logic [DW-1:0] b_out_data;
    logic          accept;
    logic          push;
    logic          rd_std;
    logic          ft_read;
    logic          ft_load;
    logic          pop;
    logic          ovalid_r;
    logic          mem_ne_d_r;
    logic [CW-1:0] mcnt_r;
    logic [CW-1:0] total_r;

    assign wr_req     = !write_en_n_i && threshold_load_n_i;
    assign ofs_wr     = !write_en_n_i && !threshold_load_n_i;
    assign ofs_rd_req = !read_en_n_i && !threshold_load_n_i;
    assign ofs_rd     = ofs_rd_req && !cfg_r.fall_through_mode;
    assign accept     = wr_req && !full_int && b_in_ready;
    assign b_out_ready = (mcnt_r != CAP_SD);
    assign push       = b_out_valid && b_out_ready;
    assign rd_std     = !cfg_r.fall_through_mode && threshold_load_n_i && !read_en_n_i
                        && (mcnt_r != '0);
    assign ft_read    = cfg_r.fall_through_mode && threshold_load_n_i && !read_en_n_i && ovalid_r;
    // The word must have sat in storage one extra edge before it falls through.
    assign ft_load    = cfg_r.fall_through_mode && mem_ne_d_r && (mcnt_r != '0)
                        && (!ovalid_r || ft_read);
    assign pop        = rd_std || ft_load;

    ////////////////////////////////////////////////////////////////////////////
    // Write-side buffer and storage.

    // The buffer lets a word be taken even when storage is busy for a cycle.
    dcf_buf2 #(
        .W (DW)
    ) u_wbuf (
        .clk_i       (clk_i),
        .nrst_i      (nrst_i),
        .in_valid_i  (wr_req && !full_int),
        .in_ready_o  (b_in_ready),
        .in_data_i   (write_data_i),
        .out_valid_o (b_out_valid),
        .out_ready_i (b_out_ready),
        .out_data_o  (b_out_data)
    );

    logic [DW-1:0] mem_r [DEPTH];
    logic [AW-1:0] wptr_r;
    logic [AW-1:0] rptr_r;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wptr_r] <= b_out_data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            wptr_r <= '0;
            rptr_r <= '0;
        end else begin
            if (push) begin
                wptr_r <= (wptr_r == PTR_MX) ? '0 : wptr_r + 1'b1;
            end
            if (pop) begin
                rptr_r <= (rptr_r == PTR_MX) ? '0 : rptr_r + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Word counts.

    logic [CW-1:0] mcnt_nxt;
    logic [CW-1:0] total_nxt;
    logic          ovalid_nxt;

    assign mcnt_nxt   = mcnt_r + CW'(push) - CW'(pop);
    assign total_nxt  = total_r + CW'(accept) - CW'(rd_std) - CW'(ft_read);
    assign ovalid_nxt = ft_load ? 1'b1 : (ft_read ? 1'b0 : ovalid_r);

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            mcnt_r     <= '0;
            total_r    <= '0;
            ovalid_r   <= 1'b0;
            mem_ne_d_r <= 1'b0;
        end else begin
            mcnt_r     <= mcnt_nxt;
            total_r    <= total_nxt;
            ovalid_r   <= ovalid_nxt;
            mem_ne_d_r <= (mcnt_r != '0);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Threshold registers and their load sequences.

    logic [dcf_pkg::OFS_W-1:0] ae_thr_r;
    logic [dcf_pkg::OFS_W-1:0] af_thr_r;
    dcf_pkg::dcf_sel_t         wsel_r;
    dcf_pkg::dcf_sel_t         rsel_r;

    // The write pointer only moves on a load write, so raising the load pin
    // between writes keeps the place in the sequence.
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ae_thr_r <= AE_DEF;
            af_thr_r <= AF_DEF;
            wsel_r   <= dcf_pkg::SEL_AE;
        end else if (ofs_wr) begin
            case (wsel_r)
                dcf_pkg::SEL_AE: begin
                    ae_thr_r <= write_data_i[dcf_pkg::OFS_W-1:0];
                    wsel_r   <= dcf_pkg::SEL_AF;
                end
                dcf_pkg::SEL_AF: begin
                    af_thr_r <= write_data_i[dcf_pkg::OFS_W-1:0];
                    wsel_r   <= dcf_pkg::SEL_AE;
                end
                default: begin
                    wsel_r <= dcf_pkg::SEL_AE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            rsel_r <= dcf_pkg::SEL_AE;
        end else if (ofs_rd) begin
            rsel_r <= (rsel_r == dcf_pkg::SEL_AE) ? dcf_pkg::SEL_AF : dcf_pkg::SEL_AE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output register and enable.

    logic [DW-1:0] q_r;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            q_r <= '0;
        end else if (rd_std || ft_load) begin
            q_r <= mem_r[rptr_r];
        end else if (ofs_rd) begin
            q_r <= (rsel_r == dcf_pkg::SEL_AE) ? DW'(ae_thr_r) : DW'(af_thr_r);
        end
    end

    assign read_data_bus_o    = q_r;
    assign read_data_bus_oe_o = !output_enable_n_i;

    ////////////////////////////////////////////////////////////////////////////
    // Status flags.

    logic                    ffir_r;
    logic                    efor_r;
    logic                    paf_r;
    logic                    pae_r;
    logic                    paf_s_r;
    logic                    pae_s_r;
    logic                    full_nxt;
    logic                    af_lvl;
    logic                    ae_lvl;
    logic [CW-1:0]           ae_lim;

    assign full_nxt = (total_nxt >= cap);
    assign af_lvl   = (total_nxt + CW'(af_thr_r)) >= cap;
    assign ae_lim   = CW'(ae_thr_r) + (cfg_r.fall_through_mode ? dcf_pkg::FT_EXTRA : '0);
    assign ae_lvl   = (total_nxt <= ae_lim);
    assign full_int = cfg_r.fall_through_mode ? ffir_r : !ffir_r;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ffir_r <= 1'b1;
        end else begin
            ffir_r <= cfg_r.fall_through_mode ? full_nxt : !full_nxt;
        end
    end

    // Output ready falls with the word and rises only after a true read.
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            efor_r <= !read_expansion_in_n_i && write_expansion_in_n_i;
        end else begin
            efor_r <= cfg_r.fall_through_mode ? !ovalid_nxt : (mcnt_nxt != '0);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            paf_r   <= 1'b1;
            pae_r   <= 1'b0;
            paf_s_r <= 1'b1;
            pae_s_r <= 1'b0;
        end else begin
            paf_r   <= !af_lvl;
            pae_r   <= !ae_lvl;
            paf_s_r <= paf_r;
            pae_s_r <= pae_r;
        end
    end

    // With one clock the synchronous partial flags add one edge of settling
    // in place of a crossing into the opposite side's domain.
    assign full_flag_n_o         = ffir_r;
    assign empty_flag_n_o        = efor_r;
    assign almost_full_flag_n_o  = cfg_r.psync ? paf_s_r : paf_r;
    assign almost_empty_flag_n_o = cfg_r.psync ? pae_s_r : pae_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    sequence ft_first_s;
        cfg_r.fall_through_mode && accept && total_r == '0 && read_en_n_i;
    endsequence

    sequence ft_wait_s;
        empty_flag_n_o [*3];
    endsequence

    oe_float_a: assert property (output_enable_n_i |-> !read_data_bus_oe_o)
        else $error("Read bus driven while output enable is high");
    thr_ae_wr_a: assert property (ofs_wr && wsel_r == dcf_pkg::SEL_AE |=>
        ae_thr_r == $past(write_data_i[dcf_pkg::OFS_W-1:0]) && wsel_r == dcf_pkg::SEL_AF)
        else $error("Almost-empty threshold not loaded on first edge");
    thr_af_wr_a: assert property (ofs_wr && wsel_r == dcf_pkg::SEL_AF |=>
        af_thr_r == $past(write_data_i[dcf_pkg::OFS_W-1:0]) && wsel_r == dcf_pkg::SEL_AE)
        else $error("Almost-full threshold not loaded on second edge");
    load_idle_a: assert property (!threshold_load_n_i && write_en_n_i |=>
        $stable(wsel_r) && $stable(total_r))
        else $error("Idle load cycle changed state");
    rd_blocked_a: assert property (cfg_r.fall_through_mode && ofs_rd_req && !ft_load |=>
        $stable(rsel_r) && $stable(read_data_bus_o))
        else $error("Threshold readback in fall-through mode");
    std_full_a: assert property (!cfg_r.fall_through_mode && total_r == CAP_SD |->
        !full_flag_n_o && !accept)
        else $error("Full flag not low at depth words");
    ft_ir_a: assert property (cfg_r.fall_through_mode && total_r == CAP_SD + dcf_pkg::FT_EXTRA |->
        full_flag_n_o && !accept)
        else $error("Input ready not high at depth plus one");
    std_empty_a: assert property (!cfg_r.fall_through_mode && mcnt_r == '0 |-> !empty_flag_n_o)
        else $error("Empty flag high with no stored words");
    ft_last_a: assert property (ft_read && !ft_load |=>
        empty_flag_n_o && read_data_bus_o == $past(read_data_bus_o))
        else $error("Output ready or data wrong after last read");
    ft_first_a: assert property (ft_first_s |=>
        ft_wait_s ##1 !empty_flag_n_o)
        else $error("First word did not fall through on third edge");
    ae_level_a: assert property (!cfg_r.psync && $stable(ae_thr_r) &&
        total_r <= ae_lim |-> !almost_empty_flag_n_o)
        else $error("Almost-empty flag high at or below threshold");
    af_level_a: assert property (!cfg_r.psync && $stable(af_thr_r) &&
        total_r + CW'(af_thr_r) >= cap |-> !almost_full_flag_n_o)
        else $error("Almost-full flag high at threshold");

endmodule

// *** sim/dcf_peer.sv ***
//////////////////////////////////////////////////////////////////////////////
// Purpose: Writer and reader model on the far side of the FIFO ports.
// Assumes: Requests change just after a falling edge of clk_i.
// Notes:   Released data shows the inverse of its last value.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module dcf_peer (
    // Clock
    input  wire logic                       clk_i,
    // Requests into the FIFO
    output logic [dcf_pkg::DATA_W-1:0]      write_data_o,
    output logic                            write_en_n_o,
    output logic                            threshold_load_n_o,
    output logic                            read_en_n_o
);
    initial begin
        write_data_o       = 18'h00000;
        write_en_n_o       = 1'b1;
        threshold_load_n_o = 1'b1;
        read_en_n_o        = 1'b1;
    end

    // One request per call, held over exactly one rising edge.
    // Calls are serial, so a threshold read never meets a threshold write.
    task automatic req(input logic ld_n, input logic wen_n, input logic ren_n,
                       input logic [dcf_pkg::DATA_W-1:0] d);
        @(negedge clk_i);
        threshold_load_n_o = ld_n;
        write_data_o       = ld_n ? d : {6'h00, d[11:0]};
        write_en_n_o       = wen_n;
        read_en_n_o        = ren_n;
        @(negedge clk_i);
        write_data_o       = ~write_data_o;
        write_en_n_o       = 1'b1;
        read_en_n_o        = 1'b1;
        threshold_load_n_o = 1'b1;
    endtask
endmodule

// *** sim/dual_clock_fifo_flags_offsets_tb_top.sv ***
//////////////////////////////////////////////////////////////////////////////
// Purpose: Self-checking bench for the FIFO flags and threshold registers.
// Assumes: Depth 256, so the reset thresholds are 31.
// Notes:   Each FIFO write and read in run is followed by idle cycles so slow flags settle.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module dual_clock_fifo_flags_offsets_tb_top;
    localparam int DEPTH = 256;
    logic                        clk_i;
    logic                        nrst_i;
    logic [dcf_pkg::DATA_W-1:0]  write_data_i;
    logic [dcf_pkg::DATA_W-1:0]  read_data_bus_o;
    logic                        write_en_n_i;
    logic                        threshold_load_n_i;
    logic                        read_en_n_i;
    logic                        output_enable_n_i;
    logic                        read_data_bus_oe_o;
    logic                        fl_n;
    logic                        wxi_n;
    logic                        rxi_n;
    logic                        ff_n;
    logic                        ef_n;
    logic                        af_n;
    logic                        ae_n;
    int                          n_mismatch;
    int                          checks;

    dcf_flags_top #(.DEPTH(DEPTH)) dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .write_data_i(write_data_i),
        .write_en_n_i(write_en_n_i), .threshold_load_n_i(threshold_load_n_i),
        .read_en_n_i(read_en_n_i), .output_enable_n_i(output_enable_n_i),
        .read_data_bus_o(read_data_bus_o), .read_data_bus_oe_o(read_data_bus_oe_o),
        .first_load_n_i(fl_n), .write_expansion_in_n_i(wxi_n),
        .read_expansion_in_n_i(rxi_n), .full_flag_n_o(ff_n), .empty_flag_n_o(ef_n),
        .almost_full_flag_n_o(af_n), .almost_empty_flag_n_o(ae_n));

    dcf_peer peer (
        .clk_i(clk_i), .write_data_o(write_data_i), .write_en_n_o(write_en_n_i),
        .threshold_load_n_o(threshold_load_n_i), .read_en_n_o(read_en_n_i));

    initial clk_i = 1'b0;
    always #(dcf_pkg::CLK_PERIOD_NS / 2) clk_i = ~clk_i;

    task automatic print_verdict();
        if (n_mismatch == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp, input string what);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t flag %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic idle(input int k);
        repeat (k) @(negedge clk_i);
    endtask

    function automatic logic [17:0] pat(input int i);
        return 18'h15000 ^ 18'(i);
    endfunction

    // Expected flag levels for a stored count c, counting the output register.
    task automatic flags(input int c, input logic ft, input int n, input int m);
        int cap;
        cap = DEPTH + (ft ? 1 : 0);
        chk1(ff_n, ft ? (c >= cap) : (c < cap), "full");
        chk1(ef_n, ft ? (c < 1) : (c >= 1), "empty");
        chk1(af_n, !(c >= cap - m), "afull");
        chk1(ae_n, !(c <= n + (ft ? 1 : 0)), "aempty");
    endtask

    task automatic do_reset(input logic ft);
        fl_n   = ft;
        rxi_n  = 1'b0;
        wxi_n  = ft;
        nrst_i = 1'b0;
        idle(6);
        chk(read_data_bus_o, 18'h00000, "reset data");
        chk1(ff_n, 1'b1, "reset full");
        chk1(ef_n, ft, "reset empty");
        chk1(af_n, 1'b1, "reset afull");
        chk1(ae_n, 1'b0, "reset aempty");
        nrst_i = 1'b1;
        idle(2);
    endtask

    task automatic rd_thr(input logic [11:0] exp);
        peer.req(1'b0, 1'b1, 1'b0, 18'h00000);
        chk(read_data_bus_o, {6'h00, exp}, "threshold");
    endtask

    // Fill one word past capacity, then drain one read past empty.
    task automatic run(input logic ft, input int n, input int m);
        int cap;
        int c;
        cap = DEPTH + (ft ? 1 : 0);
        for (int i = 0; i <= cap; i++) begin
            peer.req(1'b1, 1'b0, 1'b1, pat(i));
            if (i == 0) begin
                idle(1);
                chk1(ef_n, 1'b1, "first1");
                idle(1);
                chk1(ef_n, 1'b1, "first2");
                idle(1);
                chk1(ef_n, !ft, "first3");
                idle(1);
            end else begin
                idle(4);
            end
            flags((i < cap) ? i + 1 : cap, ft, n, m);
        end
        if (ft)
            chk(read_data_bus_o, pat(0), "fall data");
        for (int i = 0; i <= cap; i++) begin
            peer.req(1'b1, 1'b1, 1'b0, 18'h00000);
            idle(4);
            c = (i < cap) ? cap - 1 - i : 0;
            chk(read_data_bus_o, pat((i + ft < cap) ? i + ft : cap - 1), "data");
            flags(c, ft, n, m);
        end
    endtask

    initial begin
        n_mismatch        = 0;
        checks            = 0;
        output_enable_n_i = 1'b0;
        do_reset(1'b0);
        output_enable_n_i = 1'b1;
        idle(1);
        chk1(read_data_bus_oe_o, 1'b0, "oe off");
        output_enable_n_i = 1'b0;
        idle(1);
        chk1(read_data_bus_oe_o, 1'b1, "oe on");
        rd_thr(12'h01f);
        rd_thr(12'h01f);
        peer.req(1'b0, 1'b0, 1'b1, 18'h3f002);
        peer.req(1'b0, 1'b1, 1'b1, 18'h00077);
        peer.req(1'b1, 1'b1, 1'b1, 18'h00000);
        peer.req(1'b0, 1'b0, 1'b1, 18'h00005);
        idle(3);
        chk1(ef_n, 1'b0, "no write");
        rd_thr(12'h002);
        rd_thr(12'h005);
        peer.req(1'b0, 1'b0, 1'b1, 18'h00001);
        rd_thr(12'h001);
        run(1'b0, 1, 5);
        // Straps move after reset; the mode taken in reset must hold.
        do_reset(1'b1);
        fl_n  = 1'b0;
        wxi_n = 1'b0;
        run(1'b1, 31, 31);
        peer.req(1'b0, 1'b1, 1'b0, 18'h00000);
        chk(read_data_bus_o, pat(DEPTH), "no readback");
        print_verdict();
    end

    initial begin
        repeat (100000) @(posedge clk_i);
        n_mismatch++;
        $display("BAD %0t run did not finish", $time);
        print_verdict();
    end
endmodule
